// ---- dci_pkg.sv ----
package dci_pkg;
   localparam int BA_W = 3;
   localparam int A_W = 15;
   localparam int DQ_W = 16;
   localparam int LANES = 2;
   localparam int BURST = 8;
   localparam int CHOP = 4;
   // beat timing: one data beat per half link clock
   localparam int SYS_NS = 40;
   localparam int CK_HALF_NS = 160;
   localparam int HALF_CK = (CK_HALF_NS + SYS_NS - 1) / SYS_NS;
   // address bit roles
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   // mode register fields
   localparam int BL_LSB = 0;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_CHOP4 = 2'h2;
   localparam int WL_BIT = 7;
   localparam int TDQS_BIT = 11;
   localparam int NOM_B0 = 2;
   localparam int NOM_B1 = 6;
   localparam int NOM_B2 = 9;
   localparam int DYN_LSB = 9;
   localparam logic [14:0] MR_RST = 15'h0000;
   // leveling feedback bits, one per byte lane
   localparam int FB_LO = 0;
   localparam int FB_HI = 8;
   // array kept per bank: row bits and column bits used for the index
   localparam int ROW_KEEP = 2;
   localparam int COL_KEEP = 3;
   // {select, row strobe, column strobe, write enable}, all active low
   localparam logic [3:0] CMD_MODE = 4'h0;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_PRECH = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DESEL = 4'hF;
endpackage

// ---- dci_if.sv ----
`timescale 1ns/1ps
interface dci_if;
   logic                        ck;
   logic                        rst_n;
   logic                        cs_n;
   logic                        ras_n;
   logic                        cas_n;
   logic                        we_n;
   logic [dci_pkg::BA_W-1:0]    ba;
   logic [dci_pkg::A_W-1:0]     a;
   logic                        odt;
   logic [dci_pkg::LANES-1:0]   dm;
   logic [dci_pkg::DQ_W-1:0]    dq_h;
   logic                        dq_h_oe;
   logic [dci_pkg::DQ_W-1:0]    dq_d;
   logic [dci_pkg::DQ_W-1:0]    dq_d_oe;
   logic [dci_pkg::DQ_W-1:0]    dq;
   logic [dci_pkg::LANES-1:0]   dqs_t_h;
   logic [dci_pkg::LANES-1:0]   dqs_c_h;
   logic [dci_pkg::LANES-1:0]   dqs_h_oe;
   logic [dci_pkg::LANES-1:0]   dqs_t_d;
   logic [dci_pkg::LANES-1:0]   dqs_c_d;
   logic [dci_pkg::LANES-1:0]   dqs_d_oe;
   logic [dci_pkg::LANES-1:0]   dqs_t;
   logic [dci_pkg::LANES-1:0]   dqs_c;

   // wire level: device first, then host, undriven reads low
   assign dq = (dq_d & dq_d_oe) | (dq_h & ~dq_d_oe & {dci_pkg::DQ_W{dq_h_oe}});
   assign dqs_t = (dqs_t_d & dqs_d_oe) | (dqs_t_h & dqs_h_oe & ~dqs_d_oe);
   assign dqs_c = (dqs_c_d & dqs_d_oe) | (dqs_c_h & dqs_h_oe & ~dqs_d_oe);

   modport host (
      output ck, rst_n, cs_n, ras_n, cas_n, we_n, ba, a, odt, dm,
      output dq_h, dq_h_oe, dqs_t_h, dqs_c_h, dqs_h_oe,
      input  dq, dqs_t, dqs_c
   );
   modport device (
      input  ck, rst_n, cs_n, ras_n, cas_n, we_n, ba, a, odt, dm,
      input  dq, dqs_t, dqs_c,
      output dq_d, dq_d_oe, dqs_t_d, dqs_c_d, dqs_d_oe
   );
endinterface

// ---- dci_dev.sv ----
// Operation
// - masked byte lanes of write beats are not stored; the unmasked lane of the beat is still written
// - mask sampled on both strobe edges
// - bank inputs select the target bank
// - bank inputs pick the mode register
// - address bit 10 requests auto precharge
// - precharge with bit 10 closes all
// - address carries row or start column
// - address is the mode register opcode
// - bit 12 selects chop when enabled
// - termination input enables internal termination
// - termination input ignored when both disabled
// - mode bit turns mask into strobe; here the mask is only ignored, no strobe is driven
// - reset pin is asynchronous, active low
// - controller holds reset high in operation
// - leveling feedback on bits 0 and 8
// - device strobes reads, controller strobes writes
// - read strobe edge aligned, write centred
// - strobes are always differential pairs
// - deselected cycles carry no command
// - select and strobe lines encode commands
`timescale 1ns/1ps
module dci_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  buf_mem [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0]   cnt;
   logic          push;
   logic          pop;

   assign in_ready = (cnt != (PW+1)'(DEPTH));
   assign out_valid = (cnt != '0);
   assign out_data = buf_mem[rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push)
            wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         if (pop)
            rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push)
         buf_mem[wp] <= in_data;
   end
endmodule

module dci_dev #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic  sys_clk,
   input  wire logic  arst_n,
   dci_if.device      bus,
   output logic       term_on,
   output logic       tdqs_mode,
   output logic       wl_mode,
   output logic [7:0] bank_open,
   output logic       wr_overrun
);
   localparam int BW = dci_pkg::BA_W;
   localparam int AW = dci_pkg::A_W;
   localparam int DW = dci_pkg::DQ_W;
   localparam int RK = dci_pkg::ROW_KEEP;
   localparam int CK = dci_pkg::COL_KEEP;
   localparam int IW = BW + RK + CK;
   localparam int FW = dci_pkg::LANES + DW + IW;
   localparam int SW = 5 + BW + AW + 1 + dci_pkg::LANES + DW + 1;
   localparam int TW = $clog2(dci_pkg::HALF_CK);

   typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_RD_PRE, ST_RD, ST_RD_POST} dci_st_t;

   logic                        pin_rst_n;
   logic                        rs1;
   logic                        rs2;
   logic [SW-1:0]               s1;
   logic [SW-1:0]               s2;
   logic                        ck_s;
   logic [3:0]                  cmd_s;
   logic [BW-1:0]               ba_s;
   logic [AW-1:0]               a_s;
   logic                        odt_s;
   logic [dci_pkg::LANES-1:0]   dm_s;
   logic [DW-1:0]               dq_s;
   logic                        dqs_s;
   logic                        ck_d;
   logic                        dqs_d;
   logic                        ck_rise;
   logic                        dqs_edge;
   logic                        dqs_rise;
   logic                        cmd_go;
   logic [AW-1:0]               mr [4];
   logic                        chop;
   logic                        term_en;
   dci_st_t                     state;
   logic [TW-1:0]               tmr;
   logic                        tmr_wrap;
   logic [BW-1:0]               b_ba;
   logic [CK-1:0]               col;
   logic [3:0]                  left;
   logic                        auto_pre;
   logic                        burst_done;
   logic [RK-1:0]               row_q [8];
   logic [IW-1:0]               idx;
   logic [DW-1:0]               arr [2**IW];
   logic                        f_in_v;
   logic                        f_in_rdy;
   logic [FW-1:0]               f_in;
   logic                        f_out_v;
   logic                        f_out_rdy;
   logic [FW-1:0]               f_out;

   // reset pin asserts at once, releases through two flops
   assign pin_rst_n = arst_n & bus.rst_n;
   always_ff @(posedge sys_clk or negedge pin_rst_n) begin
      if (!pin_rst_n) begin
         rs1 <= 1'b0;
         rs2 <= 1'b0;
      end else begin
         rs1 <= 1'b1;
         rs2 <= rs1;
      end
   end

   // command, address, data, mask and lane 0 true strobe pins, link clock included, cross through two flops
   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         s1 <= '0;
         s2 <= '0;
         ck_d <= 1'b0;
         dqs_d <= 1'b0;
      end else begin
         s1 <= {bus.ck, bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n, bus.ba, bus.a,
                bus.odt, bus.dm, bus.dq, bus.dqs_t[0]};
         s2 <= s1;
         ck_d <= ck_s;
         dqs_d <= dqs_s;
      end
   end

   assign {ck_s, cmd_s, ba_s, a_s, odt_s, dm_s, dq_s, dqs_s} = s2;
   assign ck_rise = ck_s & ~ck_d;
   assign dqs_edge = dqs_s ^ dqs_d;
   assign dqs_rise = dqs_s & ~dqs_d;
   assign cmd_go = ck_rise & ~cmd_s[3];

   // contents start at zero; software must load them anyway
   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         for (int i = 0; i < 4; i++)
            mr[i] <= dci_pkg::MR_RST;
      end else if (cmd_go && cmd_s == dci_pkg::CMD_MODE && !ba_s[2]) begin
         mr[ba_s[1:0]] <= a_s;
      end
   end

   assign chop = (mr[0][dci_pkg::BL_LSB+:2] == dci_pkg::BL_CHOP4) ||
                 (mr[0][dci_pkg::BL_LSB+:2] == dci_pkg::BL_OTF && !a_s[dci_pkg::BC_BIT]);
   assign term_en = mr[1][dci_pkg::NOM_B0] | mr[1][dci_pkg::NOM_B1] | mr[1][dci_pkg::NOM_B2] |
                    (mr[2][dci_pkg::DYN_LSB+:2] != 2'h0);

   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         term_on <= 1'b0;
         tdqs_mode <= 1'b0;
         wl_mode <= 1'b0;
      end else begin
         if (ck_rise)
            term_on <= odt_s & term_en;
         tdqs_mode <= mr[1][dci_pkg::TDQS_BIT];
         wl_mode <= mr[1][dci_pkg::WL_BIT];
      end
   end

   assign tmr_wrap = (tmr == TW'(dci_pkg::HALF_CK - 1));
   assign burst_done = (left == 4'h1) &&
                       ((state == ST_WR && dqs_edge) || (state == ST_RD && tmr_wrap));

   // reads or writes to a closed bank are dropped
   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         state <= ST_IDLE;
         tmr <= '0;
         b_ba <= '0;
         col <= '0;
         left <= 4'h0;
         auto_pre <= 1'b0;
      end else begin
         tmr <= (state == ST_IDLE || tmr_wrap) ? '0 : tmr + 1'b1;
         case (state)
            ST_IDLE: begin
               if (cmd_go && bank_open[ba_s] &&
                   (cmd_s == dci_pkg::CMD_WRITE || cmd_s == dci_pkg::CMD_READ)) begin
                  b_ba <= ba_s;
                  col <= a_s[CK-1:0];
                  left <= chop ? 4'(dci_pkg::CHOP) : 4'(dci_pkg::BURST);
                  auto_pre <= a_s[dci_pkg::AP_BIT];
                  state <= (cmd_s == dci_pkg::CMD_WRITE) ? ST_WR : ST_RD_PRE;
               end
            end
            ST_WR: begin
               if (dqs_edge) begin
                  col <= col + 1'b1;
                  left <= left - 4'h1;
                  if (burst_done)
                     state <= ST_IDLE;
               end
            end
            ST_RD_PRE: begin
               if (tmr_wrap)
                  state <= ST_RD;
            end
            ST_RD: begin
               if (tmr_wrap) begin
                  col <= col + 1'b1;
                  left <= left - 4'h1;
                  if (burst_done)
                     state <= ST_RD_POST;
               end
            end
            ST_RD_POST: begin
               if (tmr_wrap)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         bank_open <= 8'h00;
         for (int i = 0; i < 8; i++)
            row_q[i] <= '0;
      end else begin
         if (cmd_go && cmd_s == dci_pkg::CMD_ACT) begin
            bank_open[ba_s] <= 1'b1;
            row_q[ba_s] <= a_s[RK-1:0];
         end else if (cmd_go && cmd_s == dci_pkg::CMD_PRECH) begin
            if (a_s[dci_pkg::AP_BIT])
               bank_open <= 8'h00;
            else
               bank_open[ba_s] <= 1'b0;
         end
         if (burst_done && auto_pre)
            bank_open[b_ba] <= 1'b0;
      end
   end

   assign idx = {b_ba, row_q[b_ba], col};

   // each strobe edge is one beat with its own mask; mask is dropped in strobe mode
   assign f_in_v = (state == ST_WR) && dqs_edge;
   assign f_in = {tdqs_mode ? 2'h0 : dm_s, dq_s, idx};
   // the read fetch owns the array port, so draining stalls then
   assign f_out_rdy = !(state == ST_RD && tmr == '0);

   dci_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .sys_clk   (sys_clk),
      .rst_n     (rs2),
      .in_valid  (f_in_v),
      .in_ready  (f_in_rdy),
      .in_data   (f_in),
      .out_valid (f_out_v),
      .out_ready (f_out_rdy),
      .out_data  (f_out)
   );

   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2)
         wr_overrun <= 1'b0;
      else if (f_in_v && !f_in_rdy)
         wr_overrun <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (f_out_v && f_out_rdy) begin
         for (int l = 0; l < dci_pkg::LANES; l++)
            if (!f_out[FW-dci_pkg::LANES+l])
               arr[f_out[IW-1:0]][l*8+:8] <= f_out[IW+l*8+:8];
      end
   end

   // limitation: a read right after a write may overtake queued beats
   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         bus.dq_d <= '0;
         bus.dq_d_oe <= '0;
      end else if (state == ST_RD) begin
         if (tmr == '0) begin
            bus.dq_d <= arr[idx];
            bus.dq_d_oe <= '1;
         end
      end else if (state == ST_RD_POST) begin
         bus.dq_d_oe <= '1;
      end else if (wl_mode) begin
         bus.dq_d_oe <= '0;
         bus.dq_d_oe[dci_pkg::FB_LO] <= 1'b1;
         bus.dq_d_oe[dci_pkg::FB_HI] <= 1'b1;
         if (dqs_rise) begin
            bus.dq_d[dci_pkg::FB_LO] <= ck_s;
            bus.dq_d[dci_pkg::FB_HI] <= ck_s;
         end
      end else begin
         bus.dq_d_oe <= '0;
      end
   end

   // strobe toggles with the data word: edge aligned
   always_ff @(posedge sys_clk or negedge rs2) begin
      if (!rs2) begin
         bus.dqs_t_d <= 2'h0;
         bus.dqs_c_d <= 2'h3;
         bus.dqs_d_oe <= 2'h0;
      end else begin
         bus.dqs_d_oe <= (state == ST_IDLE || state == ST_WR) ? 2'h0 : 2'h3;
         if (state == ST_RD_PRE) begin
            bus.dqs_t_d <= 2'h0;
            bus.dqs_c_d <= 2'h3;
         end else if (state == ST_RD && tmr == '0) begin
            bus.dqs_t_d <= ~bus.dqs_t_d;
            bus.dqs_c_d <= bus.dqs_t_d;
         end
      end
   end
endmodule

// ---- dci_host.sv ----
`timescale 1ns/1ps
module dci_host (
   input  wire logic                                      sys_clk,
   input  wire logic                                      arst_n,
   dci_if.host                                            bus,
   input  wire logic                                      cmd_valid,
   output logic                                           cmd_ready,
   input  wire logic [3:0]                                cmd_code,
   input  wire logic [dci_pkg::BA_W-1:0]                  cmd_ba,
   input  wire logic [dci_pkg::A_W-1:0]                   cmd_addr,
   input  wire logic [dci_pkg::BURST*dci_pkg::DQ_W-1:0]   wr_data,
   input  wire logic [dci_pkg::BURST*dci_pkg::LANES-1:0]  wr_mask,
   input  wire logic                                      odt_req,
   input  wire logic                                      mem_reset_req,
   output logic [dci_pkg::DQ_W-1:0]                       rd_data,
   output logic                                           rd_valid
);
   localparam int DW = dci_pkg::DQ_W;
   localparam int TW = $clog2(dci_pkg::HALF_CK);

   typedef enum logic [2:0] {H_IDLE, H_CMD, H_WPRE, H_WR, H_WPOST, H_RD} dci_hst_t;

   dci_hst_t                                  st;
   logic [TW-1:0]                             hcnt;
   logic [TW-1:0]                             btmr;
   logic                                      wrap;
   logic                                      bwrap;
   logic                                      fall;
   logic                                      take;
   logic [1:0]                                bl_q;
   logic [3:0]                                code_q;
   logic [3:0]                                left;
   logic [2:0]                                k;
   logic [dci_pkg::BURST*DW-1:0]              wd_q;
   logic [dci_pkg::BURST*dci_pkg::LANES-1:0]  wm_q;
   logic [DW:0]                               h1;
   logic [DW:0]                               h2;
   logic                                      dqs_hd;

   assign wrap = (hcnt == TW'(dci_pkg::HALF_CK - 1));
   assign fall = wrap & bus.ck;
   assign bwrap = (btmr == TW'(dci_pkg::HALF_CK - 1));
   assign take = cmd_valid & cmd_ready;

   // link clock made here by dividing the system clock
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hcnt <= '0;
         bus.ck <= 1'b0;
      end else begin
         hcnt <= wrap ? '0 : hcnt + 1'b1;
         if (wrap)
            bus.ck <= ~bus.ck;
      end
   end

   // ready pulses the cycle before a falling edge, so pins change mid-period
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         cmd_ready <= 1'b0;
      else
         cmd_ready <= (st == H_IDLE) && !take && bus.ck &&
                      (hcnt == TW'(dci_pkg::HALF_CK - 2));
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.rst_n <= 1'b0;
         bus.odt <= 1'b0;
      end else begin
         bus.rst_n <= ~mem_reset_req;
         if (fall)
            bus.odt <= odt_req;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         h1 <= '0;
         h2 <= '0;
         dqs_hd <= 1'b0;
      end else begin
         h1 <= {bus.dq, bus.dqs_t[0]};
         h2 <= h1;
         dqs_hd <= h2[0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= H_IDLE;
         {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= dci_pkg::CMD_DESEL;
         bus.ba <= '0;
         bus.a <= '0;
         bl_q <= dci_pkg::BL_FIXED8;
         code_q <= dci_pkg::CMD_DESEL;
         left <= 4'h0;
         k <= 3'h0;
         btmr <= '0;
         wd_q <= '0;
         wm_q <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         btmr <= (st == H_WPRE || st == H_WR || st == H_WPOST) && !bwrap ? btmr + 1'b1 : '0;
         case (st)
            H_IDLE: begin
               if (take) begin
                  {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= cmd_code;
                  bus.ba <= cmd_ba;
                  bus.a <= cmd_addr;
                  code_q <= cmd_code;
                  wd_q <= wr_data;
                  wm_q <= wr_mask;
                  if (cmd_code == dci_pkg::CMD_MODE && cmd_ba == '0)
                     bl_q <= cmd_addr[dci_pkg::BL_LSB+:2];
                  left <= ((bl_q == dci_pkg::BL_CHOP4) ||
                           (bl_q == dci_pkg::BL_OTF && !cmd_addr[dci_pkg::BC_BIT])) ?
                          4'(dci_pkg::CHOP) : 4'(dci_pkg::BURST);
                  st <= H_CMD;
               end
            end
            H_CMD: begin
               if (fall) begin
                  {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= dci_pkg::CMD_DESEL;
                  k <= 3'h0;
                  if (code_q == dci_pkg::CMD_WRITE)
                     st <= H_WPRE;
                  else if (code_q == dci_pkg::CMD_READ)
                     st <= H_RD;
                  else
                     st <= H_IDLE;
               end
            end
            H_WPRE: if (bwrap) st <= H_WR;
            H_WR: begin
               if (bwrap) begin
                  k <= k + 3'h1;
                  left <= left - 4'h1;
                  if (left == 4'h1)
                     st <= H_WPOST;
               end
            end
            H_WPOST: if (bwrap) st <= H_IDLE;
            H_RD: begin
               // edge aligned: data and strobe pass the same two flops
               if (h2[0] != dqs_hd) begin
                  rd_data <= h2[DW:1];
                  rd_valid <= 1'b1;
                  left <= left - 4'h1;
                  if (left == 4'h1)
                     st <= H_IDLE;
               end
            end
            default: st <= H_IDLE;
         endcase
      end
   end

   // write strobe toggles mid-beat: centred in the data eye
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.dq_h <= '0;
         bus.dq_h_oe <= 1'b0;
         bus.dm <= '0;
         bus.dqs_t_h <= 2'h0;
         bus.dqs_c_h <= 2'h3;
         bus.dqs_h_oe <= 2'h0;
      end else begin
         bus.dqs_h_oe <= (st == H_WPRE || st == H_WR || st == H_WPOST) ? 2'h3 : 2'h0;
         bus.dq_h_oe <= (st == H_WR || st == H_WPOST);
         if (st == H_WPRE) begin
            bus.dqs_t_h <= 2'h0;
            bus.dqs_c_h <= 2'h3;
         end
         if (st == H_WR && btmr == '0) begin
            bus.dq_h <= wd_q[k*DW+:DW];
            bus.dm <= wm_q[k*dci_pkg::LANES+:dci_pkg::LANES];
         end
         if (st == H_WR && btmr == TW'(dci_pkg::HALF_CK / 2)) begin
            bus.dqs_t_h <= ~bus.dqs_t_h;
            bus.dqs_c_h <= bus.dqs_t_h;
         end
      end
   end
endmodule

// ---- dci_sva.sv ----
`timescale 1ns/1ps
module dci_sva (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        rst_n,
   input wire logic        cs_n,
   input wire logic [2:0]  ba,
   input wire logic [14:0] a,
   input wire logic        dq_h_oe,
   input wire logic [15:0] dq_d_oe,
   input wire logic [1:0]  dqs_t_h,
   input wire logic [1:0]  dqs_c_h,
   input wire logic [1:0]  dqs_h_oe,
   input wire logic [1:0]  dqs_t_d,
   input wire logic [1:0]  dqs_c_d,
   input wire logic [1:0]  dqs_d_oe,
   input wire logic [1:0]  dqs_t
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // pairs stay complementary even in preamble
   a_host_pair: assert property ((dqs_h_oe & (dqs_t_h ^ dqs_c_h)) == dqs_h_oe)
      else $error("host strobe pair");
   a_dev_pair: assert property ((dqs_d_oe & (dqs_t_d ^ dqs_c_d)) == dqs_d_oe)
      else $error("device strobe pair");
   a_no_dq_clash: assert property (dq_h_oe |-> dq_d_oe == 16'h0000)
      else $error("data driven twice");
   a_no_dqs_clash: assert property (|dqs_d_oe |-> dqs_h_oe == 2'h0)
      else $error("strobe driven twice");
   a_write_strobed: assert property (dq_h_oe |-> dqs_h_oe == 2'h3)
      else $error("write data unstrobed");
   a_dev_reset_off: assert property (!rst_n [*3] |-> !(|{dq_d_oe, dqs_d_oe}))
      else $error("device drives in reset");
   a_cmd_hold: assert property ($fell(cs_n) |=> $stable({cs_n, ba, a}) [*3])
      else $error("command moved early");
   a_strobe_gap: assert property ($changed(dqs_t[0]) |=> !$changed(dqs_t[0]) [*2])
      else $error("strobe edges too close");
endmodule

// ---- dci_bench.sv ----
`timescale 1ns/1ps
module dci_bench;
   logic         sys_clk, arst_n, cmd_valid, cmd_ready, odt_req, mem_rst_req;
   logic [3:0]   cmd_code;
   logic [2:0]   cmd_ba;
   logic [14:0]  cmd_addr;
   logic [127:0] wr_data;
   logic [15:0]  wr_mask, rd_data;
   logic         rd_valid, term_on, tdqs_mode, wl_mode, wr_overrun;
   logic [7:0]   bank_open;
   logic [15:0]  got [8];
   int           nb;
   int           num_errors = 0;
   int           n_compared = 0;
   dci_if bus ();
   dci_host dci_host_inst (.sys_clk, .arst_n, .bus(bus), .cmd_valid, .cmd_ready, .cmd_code,
      .cmd_ba, .cmd_addr, .wr_data, .wr_mask, .odt_req, .mem_reset_req(mem_rst_req),
      .rd_data, .rd_valid);
   dci_dev #(.FIFO_DEPTH(4)) dci_dev_inst (.sys_clk, .arst_n, .bus(bus), .term_on, .tdqs_mode,
      .wl_mode, .bank_open, .wr_overrun);
   dci_sva dci_sva_inst (.sys_clk, .arst_n, .rst_n(bus.rst_n), .cs_n(bus.cs_n), .ba(bus.ba),
      .a(bus.a), .dq_h_oe(bus.dq_h_oe), .dq_d_oe(bus.dq_d_oe), .dqs_t_h(bus.dqs_t_h),
      .dqs_c_h(bus.dqs_c_h), .dqs_h_oe(bus.dqs_h_oe), .dqs_t_d(bus.dqs_t_d),
      .dqs_c_d(bus.dqs_c_d), .dqs_d_oe(bus.dqs_d_oe), .dqs_t(bus.dqs_t));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one command per ready pulse, then a fixed watch that outlasts any burst
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] ad);
      int i;
      {cmd_code, cmd_ba, cmd_addr, cmd_valid} = {c, b, ad, 1'h1};
      for (i = 0; i < 99 && cmd_ready !== 1'h1; i++) @(negedge sys_clk);
      if (i == 99) begin
         num_errors++;
         final_report();
      end
      @(negedge sys_clk);
      cmd_valid = 1'h0;
      nb = 0;
      for (i = 0; i < 150; i++) begin
         @(negedge sys_clk);
         if (rd_valid === 1'h1) begin
            got[nb%8] = rd_data;
            nb++;
         end
      end
   endtask
   initial begin
      {sys_clk, arst_n, cmd_valid, odt_req, cmd_code, cmd_ba, cmd_addr, wr_mask, wr_data} = '0;
      mem_rst_req = 1'h0;
      repeat (12) @(negedge sys_clk);
      arst_n = 1'h1;
      repeat (16) @(negedge sys_clk);
      chk(bank_open, 16'h0000, "banks");
      odt_req = 1'h1;
      cmd(dci_pkg::CMD_MODE, 3'h1, 15'h0004);
      chk(term_on, 16'h0001, "term");
      cmd(dci_pkg::CMD_MODE, 3'h1, 15'h0880);
      chk({term_on, tdqs_mode, wl_mode}, 16'h0003, "modes");
      chk(bus.dq_d_oe, 16'h0101, "level oe");
      cmd(dci_pkg::CMD_MODE, 3'h1, 15'h0000);
      cmd(dci_pkg::CMD_MODE, 3'h0, 15'h0001);
      $display("mode test done");
      cmd(dci_pkg::CMD_ACT, 3'h2, 15'h0001);
      cmd(dci_pkg::CMD_ACT, 3'h5, 15'h0002);
      // activate lines with select high
      cmd(4'hB, 3'h1, 15'h0000);
      chk(bank_open, 16'h0024, "act");
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            wr_data[k*16+:16] = {8'hA0 + 8'(p*32 + k), 8'h50 - 8'(p*32) + 8'(k)};
         end
         wr_mask = {9'h000, p[0], 6'h00};
         cmd(dci_pkg::CMD_WRITE, 3'h2, 15'h1000);
      end
      cmd(dci_pkg::CMD_READ, 3'h2, 15'h1000);
      chk(16'(nb), 16'h0008, "full beats");
      for (int k = 0; k < 8; k++) begin
         chk(got[k], {8'hC0 + 8'(k), k == 3 ? 8'h53 : 8'h30 + 8'(k)}, "data");
      end
      cmd(dci_pkg::CMD_READ, 3'h2, 15'h0400);
      chk(16'(nb), 16'h0004, "chop beats");
      chk(bank_open, 16'h0020, "auto pre");
      $display("data test done");
      cmd(dci_pkg::CMD_ACT, 3'h1, 15'h0000);
      cmd(dci_pkg::CMD_PRECH, 3'h5, 15'h0000);
      chk(bank_open, 16'h0002, "pre one");
      cmd(dci_pkg::CMD_PRECH, 3'h0, 15'h0400);
      chk({bank_open, 7'h00, wr_overrun}, 16'h0000, "pre all");
      $display("bank test done");
      // memory reset pulled mid-run: device must drop state, then accept commands again
      cmd(dci_pkg::CMD_ACT, 3'h3, 15'h0000);
      chk({7'h00, bus.rst_n, bank_open}, 16'h0108, "run");
      mem_rst_req = 1'h1;
      repeat (4) @(negedge sys_clk);
      chk({7'h00, bus.rst_n, bank_open}, 16'h0000, "in reset");
      mem_rst_req = 1'h0;
      repeat (16) @(negedge sys_clk);
      cmd(dci_pkg::CMD_ACT, 3'h4, 15'h0000);
      chk(bank_open, 16'h0010, "after reset");
      $display("reset test done");
      final_report();
   end
endmodule
